// [src/lcs_channel_irq.v]
// Line channel status flags, change latches and interrupt, APB slave
//
// Contract
// - Manual mode: flag after loop-up beyond 5s
// - Loop flag holds while pattern persists
// - Status bit 1 mirrors receive LOS
// - LOS transitions interrupt when D1 enabled
// - Status bit 0 mirrors pattern lock
// - Pattern lock transitions interrupt when D0 enabled
// - Change latches clear on read
// - Bit 6 latches driver-monitor changes
// - Bit 5 latches FIFO-limit changes
// - Bit 3 latches loop-code changes
// - Driver alarm after 128 silent bits
// - FIFO flag when pointers within three
// - Driver transitions interrupt when D6 enabled
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"

module lcs_channel_irq #(
   parameter                    PTR_W       = 4,                     // Jitter FIFO pointer width
   parameter [`LCS_LOOP_CNT_W-1:0] LOOP_PERSIST = `LCS_LOOP_PERSIST_CYC // Loop-up wait in cycles
) (
   input  wire             clk_sys,        // System clock, 20 MHz
   input  wire             reset,          // Async reset, active high
   input  wire             psel,           // APB select
   input  wire             penable,        // APB access phase
   input  wire             pwrite,         // APB write
   input  wire [7:0]       paddr,          // APB byte address
   input  wire [31:0]      pwdata,         // APB write data
   output reg  [31:0]      prdata,         // APB read data
   output reg              pready,         // APB ready
   output reg              pslverr,        // APB error, unmapped address
   input  wire             loopUpSeen,     // Detector sees loop-up code now
   input  wire             rxLossDeclared, // Receive loss of signal
   input  wire             patternLocked,  // Receive pattern lock
   input  wire             txBitTick,      // One pulse per transmit bit
   input  wire             txPulseSeen,    // Bipolar pulse on transmit output
   input  wire [PTR_W-1:0] jaReadPtr,      // Jitter FIFO read pointer
   input  wire [PTR_W-1:0] jaWritePtr,     // Jitter FIFO write pointer
   output reg              irq             // Level interrupt, active high
);

   // ----------------------------------------
   // Local constants
   // ----------------------------------------
   // Loop-code state machine, one-hot
   localparam [2:0] LC_IDLE     = 3'h1;  // No pattern or not manual
   localparam [2:0] LC_TIMING   = 3'h2;  // Pattern seen, waiting
   localparam [2:0] LC_DETECTED = 3'h4;  // Flag raised

   localparam [`LCS_DMO_CNT_W-1:0] DMO_LIMIT = `LCS_DMO_SILENT_BITS;
   localparam [31:0]               FIFO_LIM_W = `LCS_FIFO_LIMIT_BITS; // Limit at full width
   localparam [PTR_W-1:0]          FIFO_LIM  = FIFO_LIM_W[PTR_W-1:0];

   // Register select codes
   localparam [3:0] SEL_STATUS  = 4'h1;
   localparam [3:0] SEL_LATCHES = 4'h2;
   localparam [3:0] SEL_ENABLE  = 4'h4;
   localparam [3:0] SEL_CONTROL = 4'h8;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Address decode, used by read mux and write path
   function [3:0] regSelect;
      input [7:0] addr;
      begin
         case (addr)
            `LCS_ADDR_STATUS:  regSelect = SEL_STATUS;
            `LCS_ADDR_LATCHES: regSelect = SEL_LATCHES;
            `LCS_ADDR_ENABLE:  regSelect = SEL_ENABLE;
            `LCS_ADDR_CONTROL: regSelect = SEL_CONTROL;
            default:           regSelect = 4'h0;
         endcase
      end
   endfunction

   // Pointers within the limit either way round the ring
   function withinLimit;
      input [PTR_W-1:0] wr;
      input [PTR_W-1:0] rd;
      reg   [PTR_W-1:0] gap;
      begin
         gap = wr - rd;
         withinLimit = (gap <= FIFO_LIM) || (gap >= (~FIFO_LIM + 1'b1));
      end
   endfunction

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   reg  [7:0] irqEnable;     // Enable, same layout as latches
   reg  [7:0] control;       // Loop-code mode bits
   reg  [7:0] latches;       // Sticky change latches
   reg  [7:0] prevFlags;     // Flags one cycle ago
   reg  [2:0] loopState;     // Loop-code state machine
   reg  [2:0] next_loopState;
   reg  [`LCS_DMO_CNT_W-1:0] silentBits; // Bits without pulses
   reg        dmoAlarm;      // Driver-monitor alarm
   reg        fifoLimit;     // FIFO limit flag
   reg        losFlag;       // Registered loss of signal
   reg        patFlag;       // Registered pattern lock
   wire       timerExpired;  // Loop-up held long enough
   wire       loopMode;      // Manual loop-code mode selected
   wire [7:0] liveFlags;     // Status register image
   wire [7:0] changes;       // Flags that moved this cycle
   wire [7:0] clearMask;     // Bits cleared this cycle
   wire [7:0] next_latches;  // Latch value after this edge
   wire [3:0] setupSel;      // Decode in setup phase
   wire       setupPhase;    // APB setup cycle
   wire       accessDone;    // APB access completes at this edge
   wire       goodWrite;     // Mapped write completes
   wire       latchRead;     // Read of latch register completes

   // ----------------------------------------
   // Loop-code detection
   // ----------------------------------------
   assign loopMode = (control[1:0] == `LCS_MODE_MANUAL);

   lcs_persist_timer #(
      .CNT_W (`LCS_LOOP_CNT_W),
      .LIMIT (LOOP_PERSIST)
   ) u_loopTimer (
      .clk_sys (clk_sys),
      .reset   (reset),
      .run     (loopState[1] && loopMode && loopUpSeen),
      .expired (timerExpired)
   );

   // Next state; automatic mode is not built, so only manual detects
   always @* begin
      next_loopState = loopState;
      case (loopState)
         LC_IDLE: begin
            // Start timing on first sight of the code
            if (loopMode && loopUpSeen)
               next_loopState = LC_TIMING;
         end
         LC_TIMING: begin
            if (!loopMode || !loopUpSeen)
               next_loopState = LC_IDLE;
            else if (timerExpired)
               next_loopState = LC_DETECTED;
         end
         LC_DETECTED: begin
            if (!loopMode || !loopUpSeen)
               next_loopState = LC_IDLE;
         end
         default: begin
            // Illegal code, recover
            next_loopState = LC_IDLE;
         end
      endcase
   end

   // State register
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         loopState <= LC_IDLE;
      end else begin
         loopState <= next_loopState;
      end
   end

   // ----------------------------------------
   // Driver monitor, FIFO limit, mirrored flags
   // ----------------------------------------
   // Counts transmit bit periods since the last bipolar pulse.
   // A pulse wins over a tick so the alarm drops the same edge.
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         silentBits <= {`LCS_DMO_CNT_W{1'b0}};
         dmoAlarm   <= 1'b0;
      end else if (txPulseSeen) begin
         silentBits <= {`LCS_DMO_CNT_W{1'b0}};
         dmoAlarm   <= 1'b0;
      end else if (txBitTick) begin
         if (silentBits == DMO_LIMIT - 1'b1)
            dmoAlarm <= 1'b1;
         if (silentBits != DMO_LIMIT)
            silentBits <= silentBits + 1'b1;
      end
   end

   // Live flags are registered once so all change detection and the
   // status read see one consistent sample per cycle.
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fifoLimit <= 1'b0;
         losFlag   <= 1'b0;
         patFlag   <= 1'b0;
      end else begin
         fifoLimit <= withinLimit(jaWritePtr, jaReadPtr);
         losFlag   <= rxLossDeclared;
         patFlag   <= patternLocked;
      end
   end

   assign liveFlags = {1'b0, dmoAlarm, fifoLimit, 1'b0,
                       loopState[2], 1'b0, losFlag, patFlag};

   // ----------------------------------------
   // Change latches
   // ----------------------------------------
   // Previous sample for edge detection in either direction
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prevFlags <= 8'h00;
      end else begin
         prevFlags <= liveFlags;
      end
   end

   assign changes = (liveFlags ^ prevFlags) & `LCS_FLAG_MASK;

   // Only bits returned by the read are cleared, so an event that set
   // a latch between setup and access is still reported next time.
   // clear on read
   assign clearMask = (latchRead ? prdata[7:0] : 8'h00) |
                      ((goodWrite && setupSel == SEL_LATCHES) ?
                       pwdata[7:0] : 8'h00);

   // One latch per bit; set beats clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_latch
         assign next_latches[gi] = changes[gi] |
                                   (latches[gi] & ~clearMask[gi]);
      end
   endgenerate

   // Latch register
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         latches <= `LCS_RST_LATCHES;
      end else begin
         latches <= next_latches & `LCS_FLAG_MASK;
      end
   end

   // ----------------------------------------
   // Interrupt
   // ----------------------------------------
   // Registered from the next latch value so it rises with the latch
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_latches & irqEnable & `LCS_FLAG_MASK);
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   assign setupPhase = psel && !penable;
   assign setupSel   = regSelect(paddr);
   assign accessDone = psel && penable && pready;
   assign goodWrite  = accessDone && pwrite && !pslverr;
   assign latchRead  = accessDone && !pwrite && !pslverr &&
                       (setupSel == SEL_LATCHES);

   // Answer in the cycle after setup: no wait states. Read data is
   // sampled at the setup edge and held through the access phase.
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (setupPhase) begin
         // Capture answer
         pready  <= 1'b1;
         pslverr <= (setupSel == 4'h0);
         case (setupSel)
            SEL_STATUS:  prdata <= {24'h000000, liveFlags};
            SEL_LATCHES: prdata <= {24'h000000, latches};
            SEL_ENABLE:  prdata <= {24'h000000, irqEnable};
            SEL_CONTROL: prdata <= {24'h000000, control};
            default:     prdata <= 32'h0000_0000;
         endcase
      end else begin
         // Idle or access done
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Writable registers; status is read-only and ignores writes
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irqEnable <= `LCS_RST_ENABLE;
         control   <= `LCS_RST_CONTROL;
      end else if (goodWrite) begin
         if (setupSel == SEL_ENABLE)
            irqEnable <= pwdata[7:0] & `LCS_FLAG_MASK;
         if (setupSel == SEL_CONTROL)
            control <= pwdata[7:0] & `LCS_CTRL_MASK;
      end
   end

endmodule // lcs_channel_irq

`default_nettype wire

// [src/lcs_consts.vh]
// Constants for the line channel status and change-interrupt block
`ifndef LCS_CONSTS_VH
`define LCS_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define LCS_ADDR_STATUS   8'h00
`define LCS_ADDR_LATCHES  8'h04
`define LCS_ADDR_ENABLE   8'h08
`define LCS_ADDR_CONTROL  8'h0C

// ----------------------------------------
// Bit positions, shared by status, latches and enable
// ----------------------------------------
`define LCS_BIT_DMO       6
`define LCS_BIT_FIFO      5
`define LCS_BIT_LOOP      3
`define LCS_BIT_LOS       1
`define LCS_BIT_PAT       0

// Implemented bits; all others read as zero
`define LCS_FLAG_MASK     8'h6B
`define LCS_CTRL_MASK     8'h03

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCS_RST_ENABLE    8'h00
`define LCS_RST_CONTROL   8'h00
`define LCS_RST_LATCHES   8'h00

// Loop-code mode field value for manual detection
`define LCS_MODE_MANUAL   2'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define LCS_CLK_HZ            20000000
`define LCS_LOOP_PERSIST_S    5
// Five seconds of the 20 MHz clock, sized to the counter width
`define LCS_LOOP_PERSIST_CYC  27'h5F5E100
`define LCS_LOOP_CNT_W        27
`define LCS_DMO_SILENT_BITS   8'h80
`define LCS_DMO_CNT_W         8
`define LCS_FIFO_LIMIT_BITS   3

`endif

// [src/lcs_persist_timer.v]
// Persistence timer: flags a condition that has held beyond a limit
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"

module lcs_persist_timer #(
   parameter             CNT_W = `LCS_LOOP_CNT_W,        // Counter width
   parameter [CNT_W-1:0] LIMIT = `LCS_LOOP_PERSIST_CYC   // Cycles to exceed
) (
   input  wire clk_sys,   // System clock
   input  wire reset,     // Async reset, active high
   input  wire run,       // Condition present, keep counting
   output reg  expired    // Condition held beyond LIMIT
);

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   reg [CNT_W-1:0] count;  // Cycles the condition has held

   // Restart on any gap; saturate once expired
   // Dropping run clears expired at once, so a short glitch in the
   // condition costs the whole wait again; that is intended.
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count   <= {CNT_W{1'b0}};
         expired <= 1'b0;
      end else if (!run) begin
         // Gap in the condition
         count   <= {CNT_W{1'b0}};
         expired <= 1'b0;
      end else if (count == LIMIT) begin
         // Held past the limit
         expired <= 1'b1;
      end else begin
         // Still timing
         count   <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

endmodule // lcs_persist_timer

`default_nettype wire

// [verif/lcs_channel_irq_chk.sv]
// Assertion checker for the channel status block ports
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"
module lcs_channel_irq_chk #(parameter PTR_W = 4) (
   input wire logic             clk_sys,        // System clock
   input wire logic             reset,          // Async reset, active high
   input wire logic             psel,           // APB select
   input wire logic             penable,        // APB access phase
   input wire logic             pwrite,         // APB write
   input wire logic [7:0]       paddr,          // APB address
   input wire logic [31:0]      pwdata,         // APB write data
   input wire logic [31:0]      prdata,         // APB read data
   input wire logic             pready,         // APB ready
   input wire logic             pslverr,        // APB error
   input wire logic             loopUpSeen,     // Loop-up code seen
   input wire logic             rxLossDeclared, // Receive loss of signal
   input wire logic             patternLocked,  // Pattern lock
   input wire logic             txBitTick,      // Transmit bit tick
   input wire logic             txPulseSeen,    // Transmit activity
   input wire logic [PTR_W-1:0] jaReadPtr,      // Jitter FIFO read pointer
   input wire logic [PTR_W-1:0] jaWritePtr,     // Jitter FIFO write pointer
   input wire logic             irq             // Level interrupt
);
   logic [7:0]         enShadow; // Enables as last written
   logic [2:0]         quiet;    // Cycles of unchanged line inputs
   logic [2*PTR_W+4:0] linePrev; // Line inputs one cycle ago
   wire  [2*PTR_W+4:0] lineNow = {loopUpSeen, rxLossDeclared, patternLocked, txBitTick, txPulseSeen, jaReadPtr,
                                  jaWritePtr};
   wire                setupRd = psel && !penable && !pwrite;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Shadow enables; time quiet spells, since latches only settle once inputs rest
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         enShadow <= 8'h00;
         quiet    <= 3'h0;
         linePrev <= '0;
      end else begin
         linePrev <= lineNow;
         quiet    <= (lineNow != linePrev) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
         if (psel && penable && pready && pwrite && paddr == `LCS_ADDR_ENABLE) enShadow <= pwdata[7:0] & 8'h6B;
      end
   end
   sequence s_latchRead;
      setupRd && paddr == `LCS_ADDR_LATCHES ##1 penable && pready;
   endsequence
   property p_ready;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("ready not one cycle");
   property p_resv;
      pready |-> prdata[31:8] == 24'h0 && (prdata[7:0] & 8'h94) == 8'h00;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit set");
   property p_unmapped;
      psel && !penable && (paddr > 8'h0C || paddr[1:0] != 2'h0) |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_los;
      setupRd && paddr == 8'h00 && !$past(reset) && $stable(rxLossDeclared) |=> prdata[1] == $past(rxLossDeclared);
   endproperty
   a_los: assert property (p_los) else $error("loss flag wrong");
   property p_pat;
      setupRd && paddr == 8'h00 && !$past(reset) && $stable(patternLocked) |=> prdata[0] == $past(patternLocked);
   endproperty
   a_pat: assert property (p_pat) else $error("lock flag wrong");
   property p_clear;
      s_latchRead ##2 (setupRd && paddr == `LCS_ADDR_LATCHES && quiet >= 3'h6 && !loopUpSeen) |=> prdata[7:0] == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("latches not cleared");
   property p_irqOn;
      (enShadow[1] && $changed(rxLossDeclared) || enShadow[0] && $changed(patternLocked)) && !$past(reset) |-> ##[1:3] irq;
   endproperty
   a_irqOn: assert property (p_irqOn) else $error("interrupt missing");
   property p_irqOff;
      enShadow == 8'h00 && $past(enShadow) == 8'h00 |-> !irq;
   endproperty
   a_irqOff: assert property (p_irqOff) else $error("masked interrupt seen");
endmodule // lcs_channel_irq_chk
bind lcs_channel_irq lcs_channel_irq_chk #(.PTR_W(PTR_W)) chk (.clk_sys(clk_sys), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .loopUpSeen(loopUpSeen), .rxLossDeclared(rxLossDeclared), .patternLocked(patternLocked),
   .txBitTick(txBitTick), .txPulseSeen(txPulseSeen), .jaReadPtr(jaReadPtr), .jaWritePtr(jaWritePtr), .irq(irq));
`default_nettype wire

// [verif/lcs_host_model.sv]
// Host processor model: APB master for the channel registers
`timescale 1ns/1ps
`default_nettype none
module lcs_host_model (
   input  wire logic        clk_sys, // System clock
   output var  logic        psel,    // APB select
   output var  logic        penable, // APB access phase
   output var  logic        pwrite,  // APB write
   output var  logic [7:0]  paddr,   // APB address
   output var  logic [31:0] pwdata,  // APB write data
   input  wire logic [31:0] prdata,  // APB read data
   input  wire logic        pready,  // APB ready
   input  wire logic        pslverr, // APB error
   output var  logic        hung     // No answer came
);
   // single rail assumed
   // Line and framer are taken as already in single-rail mode
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      hung    = 1'b0;
   end
   // One transfer; the leading edge keeps back-to-back calls off one time step
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                       output logic err);
      int n;
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      if (n == 16) hung <= 1'b1;
      q       = prdata[7:0];
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // lcs_host_model
`default_nettype wire

// [verif/liu_channel_status_interrupts_tb.sv]
// Self-checking testbench for the channel status block
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"
module liu_channel_status_interrupts_tb;
   logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr, irq, hung, err;
   logic        loopUpSeen, rxLossDeclared, patternLocked, txBitTick, txPulseSeen;
   logic [7:0]  paddr, q, v, ch;
   logic [31:0] pwdata, prdata;
   logic [3:0]  jaReadPtr, jaWritePtr;
   int          miscompares, total_checks, i, m;
   lcs_channel_irq #(.PTR_W(4), .LOOP_PERSIST(27'd20)) DUT (.clk_sys(clk_sys), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .loopUpSeen(loopUpSeen), .rxLossDeclared(rxLossDeclared), .patternLocked(patternLocked),
      .txBitTick(txBitTick), .txPulseSeen(txPulseSeen), .jaReadPtr(jaReadPtr), .jaWritePtr(jaWritePtr), .irq(irq));
   lcs_host_model host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung(hung));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      host.xfer(1'b0, a, 8'h00, q, err);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q, err);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Pointer distance counts as near within three either way
   function automatic logic [7:0] nearFlag(input logic [3:0] d);
      return {7'h0, d <= 4'h3 || d >= 4'hD};
   endfunction
   task test_done;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // A transfer that never answers ends the run
   always @(posedge hung) begin
      miscompares++;
      test_done;
   end
   initial begin
      {reset, loopUpSeen, rxLossDeclared, patternLocked, txBitTick, txPulseSeen} = 6'h20;
      {jaReadPtr, jaWritePtr, miscompares, total_checks} = '0;
      v = 8'($urandom(59603));
      wt(5);
      reset <= 1'b0;
      wt(3);
      rd(8'h00); chk("status", q, 8'h20);
      rd(8'h04); chk("latches", q, 8'h20);
      rd(8'h04); chk("latches", q, 8'h00);
      wr(8'h00, 8'hFF); rd(8'h00); chk("status", q, 8'h20);
      rd(8'h10); chk("unmapped", {7'h0, err}, 8'h01);
      wr(8'h08, 8'hFF); rd(8'h08); chk("enable", q, 8'h6B);
      $display("test registers done");
      for (i = 0; i < 8; i++) begin
         v = 8'($urandom);
         ch = {6'h0, v[0] ^ rxLossDeclared, v[1] ^ patternLocked};
         rxLossDeclared <= v[0];
         patternLocked  <= v[1];
         wt(4);
         chk("irq", {7'h0, irq}, {7'h0, |ch});
         rd(8'h00); chk("status", q, {6'h8, v[0], v[1]});
         rd(8'h04); chk("latches", q, ch);
      end
      wr(8'h08, 8'h01);
      rxLossDeclared <= ~rxLossDeclared;
      wt(4);
      chk("irq", {7'h0, irq}, 8'h00);
      patternLocked <= ~patternLocked;
      wt(4);
      chk("irq", {7'h0, irq}, 8'h01);
      // Second lock change lands on the edge that clears the returned lock latch
      fork
         rd(8'h04);
         begin @(posedge clk_sys); patternLocked <= ~patternLocked; end
      join
      chk("latches", q, 8'h03);
      wt(2); chk("irq", {7'h0, irq}, 8'h01);
      rd(8'h04); chk("latches", q, 8'h01);
      $display("test mask done");
      txPulseSeen <= 1'b1; wt(1); txPulseSeen <= 1'b0;
      for (i = 0; i < 128; i++) begin
         @(posedge clk_sys) txBitTick <= 1'b1;
         @(posedge clk_sys) txBitTick <= 1'b0;
         if (i >= 126) begin wt(2); rd(8'h00); chk("alarm", {7'h0, q[6]}, {7'h0, i == 127}); end
      end
      wr(8'h08, 8'h40); rd(8'h04); chk("latches", q, 8'h40);
      txPulseSeen <= 1'b1; wt(1); txPulseSeen <= 1'b0; wt(3);
      chk("irq", {7'h0, irq}, 8'h01);
      rd(8'h00); chk("alarm", {7'h0, q[6]}, 8'h00);
      rd(8'h04); chk("latches", q, 8'h40);
      $display("test alarm done");
      for (i = 0; i < 8; i++) begin
         v = 8'($urandom);
         if (i < 4) v[3:0] = (i < 2) ? 4'(3 + i) : 4'(10 + i);
         jaReadPtr  <= v[7:4];
         jaWritePtr <= v[7:4] + v[3:0];
         wt(3); rd(8'h00); chk("fifo", {7'h0, q[5]}, nearFlag(v[3:0]));
      end
      jaReadPtr <= 4'h0; jaWritePtr <= 4'h0; wt(3); rd(8'h04);
      jaWritePtr <= 4'h8; wt(3); rd(8'h04); chk("fifochg", {7'h0, q[5]}, 8'h01);
      jaWritePtr <= 4'h0;
      $display("test fifo done");
      for (m = 0; m < 4; m++) begin
         wr(8'h0C, 8'(m)); rd(8'h04); loopUpSeen <= 1'b1;
         wt(14); rd(8'h00); chk("loop", {7'h0, q[3]}, 8'h00);
         wt(25); rd(8'h00); chk("loop", {7'h0, q[3]}, {7'h0, m == 1});
         loopUpSeen <= 1'b0;
         wt(3); rd(8'h04); chk("loopchg", {7'h0, q[3]}, {7'h0, m == 1});
      end
      rd(8'h04); rd(8'h04); chk("latches", q, 8'h00);
      rxLossDeclared <= ~rxLossDeclared;
      wt(4); wr(8'h04, 8'h02); rd(8'h04); chk("w1c", q, 8'h00);
      rd(8'h0C); chk("control", q, 8'h03);
      $display("test loop done");
      test_done;
   end
endmodule // liu_channel_status_interrupts_tb
`default_nettype wire
